/* src/inrush_seq_consts.svh */
// Offsets, field positions, reset values and timing figures for the
// insertion power sequencer. Included by the top module only.
`ifndef INRUSH_SEQ_CONSTS_SVH
`define INRUSH_SEQ_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define REG_CONTROL      4'h0
`define REG_ALERT_EN     4'h4
`define REG_FAULT_LOG    4'h8
`define REG_STATUS       4'hC

// Control register fields
`define CTL_OV_RETRY     0
`define CTL_UV_RETRY     1
`define CTL_OC_RETRY     2
`define CTL_FET_ON       3
`define CTL_SECOND_POWER_GOOD_IO_LSB     4
`define CTL_SECOND_POWER_GOOD_IO_OUT     6
`define CTL_PB_RETRY     7
`define CTL_RESET        8'h03
`define ALERT_EN_RESET   8'h00

// Fault log fields
`define FLT_OV           0
`define FLT_UV           1
`define FLT_OC           2
`define FLT_PB           3
`define FLT_SC           4
`define FLT_EN           5
`define FLT_EXT          7

// Timing: nominal delay for 1 uF, breaker timeout, clock rate
`define NOMINAL_DELAY_MS 256
`define BREAKER_TIME_US  530
`define CLK_FREQ_KHZ     10000

`endif

/* src/inrush_seq_pkg.sv */
// Types shared by the insertion power sequencer.
// Constants live in inrush_seq_consts.svh.
package inrush_seq_pkg;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_OFF, ST_STARTUP, ST_READY, ST_ON_WAIT, ST_PG1_DLY, ST_PG2_DLY,
      ST_WATCH, ST_RUN, ST_OV_HOLD, ST_RETRY, ST_LATCHED
   } seq_state_e;

   // Analog comparator outputs, one bit each, high = condition true
   typedef struct packed {
      logic supply_ok;     // both supply lockouts released
      logic uvh_above;     // undervoltage-high input above threshold
      logic uvl_above;     // undervoltage-low input above threshold
      logic uvl_reset;     // undervoltage-low input below reset level
      logic ov_above;      // overvoltage input above threshold
      logic drain_low;     // drain within power-good window
      logic gate_high;     // gate fully enhanced
      logic overcurrent;   // current limit active
      logic short_circuit; // catastrophic short
   } cmp_in_s;

   // SECOND_POWER_GOOD_IO pin modes
   typedef enum logic [1:0] {
      SECOND_POWER_GOOD_IO_SECOND_PG, SECOND_POWER_GOOD_IO_GP_OUT, SECOND_POWER_GOOD_IO_GP_IN, SECOND_POWER_GOOD_IO_HIZ
   } second_power_good_io_mode_e;

endpackage

/* src/insertion_power_sequencer.sv */
// Insertion power sequencer: gate control, fault log, power-good
// sequencing and alert. Assumes one 10 MHz clock, a synchronous
// power-on reset, asynchronous comparators and pins, AXI4-Lite host.
//
// Behaviour
// - Enable pin low permits turn-on after startup delay; high holds off.
// - Each enable pin level change sets an event bit in the log.
// - Enable falling edge clears faults and loads FET-on bit from on pin.
// - External fault pin low latches its log bit; gate unaffected.
// - On pin rising edge commands gate on, falling edge commands off.
// - After reset FET-on bit follows on pin one timer period later.
// - On pin falling edge clears all logged faults.
// - Enabled logged faults pull the open-drain alert output low.
// - Gate high and drain low give first power good after delay.
// - Power good clears on every gate pull-down except overvoltage with ov retry set.
// - Overvoltage turns gate off; keeps both power goods if ov retry set.
// - Second power good follows first by two delays by default.
// - Watchdog input must go low in time, else latch off (retry if pb retry set), power bad.
// - Watchdog starts when second power good latches; four periods.
// - Delays: startup, uv/pb retry one; pg two; watchdog, oc four.
// - Timed retry for all faults except overvoltage.
// - Overcurrent lasting full breaker timeout turns gate off.
// - Short circuit pulls gate down at once, no delay.
// - Gate off until lockouts, uv, ov ok and startup delay done.
// - Undervoltage-low trip turns gate off, releases both power goods.
// - Undervoltage-low below reset level clears faults, allows restart.
// - Turn-on needs undervoltage-high comparator above threshold.
// - Startup condition lost during delay restarts it from zero.
`include "inrush_seq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module insertion_power_sequencer #(
   parameter int NOMINAL_CYCLES = `NOMINAL_DELAY_MS * `CLK_FREQ_KHZ,
   parameter int BREAKER_CYCLES = `BREAKER_TIME_US * `CLK_FREQ_KHZ / 1000
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Comparators and pins
   input  wire inrush_seq_pkg::cmp_in_s cmp_in,
   input  wire logic                   enable_n_in,
   input  wire logic                   on_in,
   input  wire logic                   external_fault_in,
   input  wire logic                   power_good_watchdog_in,
   // Gate drive
   output var  logic                   gate_on,
   output var  logic                   gate_pulldown,
   // Open-drain outputs, enable low while pulling low
   output var  logic                   first_power_good_n_oe_n,
   output var  logic                   alert_n_oe_n,
   input  wire logic                   second_power_good_io_in,
   output var  logic                   second_power_good_io_out,
   output var  logic                   second_power_good_io_oe_n,
   // AXI4-Lite slave
   input  wire logic [3:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output var  logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output var  logic                   s_axi_wready,
   output var  logic [1:0]             s_axi_bresp,
   output var  logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [3:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output var  logic                   s_axi_arready,
   output var  logic [31:0]            s_axi_rdata,
   output var  logic [1:0]             s_axi_rresp,
   output var  logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   import inrush_seq_pkg::*;

   localparam int NIN = 14;

   logic [NIN-1:0] raw_in, s1_r, s2_r, s3_r, filt_r;
   cmp_in_s        cmp;
   logic           en_f, on_f, ext_f, wdog_f, second_power_good_io_f, en_d_r, on_d_r;
   logic           en_fall, en_edge, on_rise, on_fall;
   seq_state_e     state_r, state_nxt;
   logic [31:0]    per_cnt_r;
   logic [2:0]     mult_r, target;
   logic           per_tick, tmr_done, boot_r;
   logic [31:0]    cb_cnt_r;
   logic           cb_expired, start_ok, pg_cond, gate_nxt, pg_keep;
   logic [7:0]     ctl_r, alert_en_r, fault_r, fault_nxt, flt_set;
   logic [2:0]     retry_mult_r, retry_mult_nxt;
   logic           clear_all, pg1_r, pg2_r;
   logic [3:0]     aw_addr_r, ar_addr_r;
   logic [31:0]    w_data_r;
   logic [3:0]     w_strb_r;
   logic           aw_full_r, w_full_r, wr_fire;
   second_power_good_io_mode_e     second_power_good_io_mode;

   // input synchroniser
   // Three stages; a change is accepted once stages two and three agree
   assign raw_in = {cmp_in, enable_n_in, on_in, external_fault_in,
                    power_good_watchdog_in, second_power_good_io_in};
   always_ff @(posedge clk)
   begin
      s1_r <= raw_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   // Filtered level per input, reset to the inactive pin levels
   for (genvar i = 0; i < NIN; i++)
   begin : g_filt
      always_ff @(posedge clk)
      begin
         if (reset)
            filt_r[i] <= (i == 1 || i == 2 || i == 4);
         else if (s2_r[i] == s3_r[i])
            filt_r[i] <= s3_r[i];
      end
   end

   assign cmp    = cmp_in_s'(filt_r[NIN-1:5]);
   assign en_f   = filt_r[4];
   assign on_f   = filt_r[3];
   assign ext_f  = filt_r[2];
   assign wdog_f = filt_r[1];
   assign second_power_good_io_f = filt_r[0];

   // Previous levels for edge detection on the filtered pins
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         en_d_r <= 1'b1;
         on_d_r <= 1'b0;
      end
      else
      begin
         en_d_r <= en_f;
         on_d_r <= on_f;
      end
   end

   assign en_edge = en_f ^ en_d_r;
   assign en_fall = en_d_r & ~en_f;
   assign on_rise = on_f & ~on_d_r;
   assign on_fall = on_d_r & ~on_f;

   // nominal delay divider
   // Restarts on every state change so each delay is measured whole
   assign per_tick = (per_cnt_r == 32'(NOMINAL_CYCLES - 1));
   always_ff @(posedge clk)
   begin
      if (reset || state_nxt != state_r)
      begin
         per_cnt_r <= 32'h0000_0000;
         mult_r    <= 3'h0;
      end
      else if (per_tick)
      begin
         per_cnt_r <= 32'h0000_0000;
         mult_r    <= mult_r + 3'h1;
      end
      else
         per_cnt_r <= per_cnt_r + 32'h0000_0001;
   end

   always_comb
   begin
      unique case (state_r)
         ST_PG1_DLY, ST_PG2_DLY: target = 3'h2;
         ST_WATCH:               target = 3'h4;
         ST_RETRY:               target = retry_mult_r;
         default:                target = 3'h1;
      endcase
   end
   assign tmr_done = per_tick && (mult_r + 3'h1 == target);

   // circuit breaker timer
   // Runs only while the gate is on and the limit stays active
   assign cb_expired = (cb_cnt_r == 32'(BREAKER_CYCLES - 1));
   always_ff @(posedge clk)
   begin
      if (reset || !cmp.overcurrent || !gate_on)
         cb_cnt_r <= 32'h0000_0000;
      else if (!cb_expired)
         cb_cnt_r <= cb_cnt_r + 32'h0000_0001;
   end

   assign start_ok = cmp.supply_ok & cmp.uvh_above & cmp.uvl_above &
                     ~cmp.ov_above & ~en_f;
   assign pg_cond  = cmp.gate_high & cmp.drain_low;

   // Sequencer next state and fault events
   always_comb
   begin
      state_nxt      = state_r;
      flt_set        = 8'h00;
      retry_mult_nxt = retry_mult_r;
      if (!ext_f)
         flt_set[`FLT_EXT] = 1'b1;
      if (en_edge)
         flt_set[`FLT_EN] = 1'b1;
      unique case (state_r)
         ST_OFF:
            if (start_ok)
               state_nxt = ST_STARTUP;
         ST_STARTUP:
            if (!start_ok)
               state_nxt = ST_OFF;
            else if (tmr_done)
               state_nxt = ST_READY;
         ST_READY:
            if (!start_ok)
               state_nxt = ST_OFF;
            else if (ctl_r[`CTL_FET_ON])
               state_nxt = ST_ON_WAIT;
         ST_OV_HOLD:
            if (en_f || !cmp.uvl_above || !cmp.supply_ok)
               state_nxt = ST_OFF;
            else if (!cmp.ov_above && ctl_r[`CTL_FET_ON])
               state_nxt = pg2_r ? ST_RUN : ST_ON_WAIT;
         ST_RETRY:
            if (tmr_done)
               state_nxt = start_ok ? ST_READY : ST_OFF;
         // Stays until the latching fault bits are cleared
         ST_LATCHED:
            if ((fault_r & 8'h1F) == 8'h00)
               state_nxt = ST_OFF;
         default:
         begin
            // Gate-on states; pg sequencing first, faults override
            unique case (state_r)
               ST_ON_WAIT:
                  if (pg_cond)
                     state_nxt = ST_PG1_DLY;
               ST_PG1_DLY:
                  if (!pg_cond)
                     state_nxt = ST_ON_WAIT;
                  else if (tmr_done)
                     state_nxt = ST_PG2_DLY;
               ST_PG2_DLY:
                  if (tmr_done)
                     state_nxt = ST_WATCH;
               ST_WATCH:
                  if (!wdog_f)
                     state_nxt = ST_RUN;
                  else if (tmr_done)
                  begin
                     flt_set[`FLT_PB] = 1'b1;
                     state_nxt = ctl_r[`CTL_PB_RETRY] ? ST_RETRY
                                                      : ST_LATCHED;
                     retry_mult_nxt = 3'h1;
                  end
               default:
                  state_nxt = state_r;
            endcase
            if (cmp.short_circuit)
            begin
               flt_set[`FLT_SC] = 1'b1;
               state_nxt = ctl_r[`CTL_OC_RETRY] ? ST_RETRY : ST_LATCHED;
               retry_mult_nxt = 3'h4;
            end
            else if (!cmp.uvl_above || !cmp.supply_ok)
            begin
               flt_set[`FLT_UV] = 1'b1;
               state_nxt = ctl_r[`CTL_UV_RETRY] ? ST_RETRY : ST_LATCHED;
               retry_mult_nxt = 3'h1;
            end
            else if (en_f || !ctl_r[`CTL_FET_ON])
               state_nxt = ST_OFF;
            else if (cmp.ov_above)
            begin
               flt_set[`FLT_OV] = 1'b1;
               state_nxt = ctl_r[`CTL_OV_RETRY] ? ST_OV_HOLD : ST_LATCHED;
            end
            else if (cb_expired)
            begin
               flt_set[`FLT_OC] = 1'b1;
               state_nxt = ctl_r[`CTL_OC_RETRY] ? ST_RETRY : ST_LATCHED;
               retry_mult_nxt = 3'h4;
            end
         end
      endcase
   end

   assign gate_nxt = (state_nxt == ST_ON_WAIT) || (state_nxt == ST_PG1_DLY)
                  || (state_nxt == ST_PG2_DLY) || (state_nxt == ST_WATCH)
                  || (state_nxt == ST_RUN);

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r      <= ST_OFF;
         retry_mult_r <= 3'h1;
      end
      else
      begin
         state_r      <= state_nxt;
         retry_mult_r <= retry_mult_nxt;
      end
   end

   // Gate drive; strong pull-down whenever the gate is not enabled
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         gate_on       <= 1'b0;
         gate_pulldown <= 1'b1;
      end
      else
      begin
         gate_on       <= gate_nxt;
         gate_pulldown <= ~gate_nxt;
      end
   end

   assign pg_keep = gate_nxt || (state_nxt == ST_OV_HOLD);

   // Power good flags
   always_ff @(posedge clk)
   begin
      if (reset || !pg_keep)
      begin
         pg1_r <= 1'b0;
         pg2_r <= 1'b0;
      end
      else
      begin
         if (state_r == ST_PG1_DLY && state_nxt == ST_PG2_DLY)
            pg1_r <= 1'b1;
         if (state_r == ST_PG2_DLY && state_nxt == ST_WATCH)
            pg2_r <= 1'b1;
      end
   end

   assign clear_all = en_fall | on_fall | cmp.uvl_reset;

   // Fault log: hardware set wins over any clear in the same cycle
   always_comb
   begin
      fault_nxt = fault_r;
      if (clear_all)
         fault_nxt = 8'h00;
      else if (wr_fire && aw_addr_r == `REG_FAULT_LOG && w_strb_r[0])
         fault_nxt = fault_r & ~w_data_r[7:0];
      fault_nxt = fault_nxt | flt_set;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         fault_r <= 8'h00;
      else
         fault_r <= fault_nxt;
   end

   // Control and alert enable registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctl_r      <= `CTL_RESET;
         alert_en_r <= `ALERT_EN_RESET;
         boot_r     <= 1'b1;
      end
      else
      begin
         if (wr_fire && aw_addr_r == `REG_CONTROL && w_strb_r[0])
            ctl_r <= w_data_r[7:0];
         if (wr_fire && aw_addr_r == `REG_ALERT_EN && w_strb_r[0])
            alert_en_r <= w_data_r[7:0];
         if (boot_r && per_tick)
         begin
            boot_r <= 1'b0;
            if (on_f)
               ctl_r[`CTL_FET_ON] <= 1'b1;
         end
         // on pin edges
         // Pin edges wait for the power-up tick, else filters filling
         // after reset would set the bit a whole period early
         if (!boot_r && on_rise)
            ctl_r[`CTL_FET_ON] <= 1'b1;
         else if (!boot_r && on_fall)
            ctl_r[`CTL_FET_ON] <= 1'b0;
         if (!boot_r && en_fall)
            ctl_r[`CTL_FET_ON] <= on_f;
      end
   end

   assign second_power_good_io_mode = second_power_good_io_mode_e'(ctl_r[`CTL_SECOND_POWER_GOOD_IO_LSB +: 2]);

   // Open-drain outputs; enables low while pulling the pin low
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         first_power_good_n_oe_n   <= 1'b1;
         second_power_good_io_oe_n <= 1'b1;
         second_power_good_io_out  <= 1'b0;
         alert_n_oe_n              <= 1'b1;
      end
      else
      begin
         first_power_good_n_oe_n <= ~pg1_r;
         unique case (second_power_good_io_mode)
            SECOND_POWER_GOOD_IO_SECOND_PG: second_power_good_io_oe_n <= ~pg2_r;
            SECOND_POWER_GOOD_IO_GP_OUT:    second_power_good_io_oe_n <= ctl_r[`CTL_SECOND_POWER_GOOD_IO_OUT];
            default:        second_power_good_io_oe_n <= 1'b1;
         endcase
         second_power_good_io_out <= 1'b0;
         alert_n_oe_n <= ~|(fault_nxt & alert_en_r);
      end
   end

   // AXI4-Lite write: address and data taken in either order
   assign wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         aw_addr_r     <= 4'h0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         s_axi_awready <= ~aw_full_r & ~s_axi_awready;
         s_axi_wready  <= ~w_full_r & ~s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[3:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_full_r    <= 1'b0;
            w_full_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Status is read-only and answers writes with slave error
            s_axi_bresp  <= (aw_addr_r == `REG_STATUS) ? 2'h2 : 2'h0;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read: one cycle address phase, data the next
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
         ar_addr_r     <= 4'h0;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            ar_addr_r    <= s_axi_araddr;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            unique case ({s_axi_araddr[3:2], 2'h0})
               `REG_CONTROL:   s_axi_rdata <= {24'h0, ctl_r};
               `REG_ALERT_EN:  s_axi_rdata <= {24'h0, alert_en_r};
               `REG_FAULT_LOG: s_axi_rdata <= {24'h0, fault_r};
               default:
                  s_axi_rdata <= {12'h0, 4'(state_r), filt_r, pg2_r, pg1_r};
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

/* tb/converter_model.sv */
// Load, pass transistor and downstream converter seen by the sequencer.
// Assumes the bench resolves the open-drain second power-good pin.
`timescale 1ns/1ps
`default_nettype none
module converter_model (
   // Clock and scenario control
   input wire logic clk,
   input wire logic fail,
   // Device side
   input wire logic gate_on,
   input wire logic pg2_n,
   // Sense and watchdog
   output var logic gate_high,
   output var logic drain_low,
   output var logic wdog_n
);
   logic [2:0] ramp_r = 3'h0;
   int         cnt_r = 0;
   // Output charges a few cycles after the gate opens
   always_ff @(posedge clk)
   begin
      ramp_r <= {ramp_r[1:0], gate_on};
      cnt_r <= pg2_n ? 0 : cnt_r + 1;
   end
   assign gate_high = ramp_r[2];
   assign drain_low = ramp_r[2];
   // reports good well inside the check window unless told to fail
   assign wdog_n = pg2_n | fail | (cnt_r < 10);
endmodule
`default_nettype wire

/* tb/inrush_seq_monitor.sv */
// Pin and handshake checks for the insertion power sequencer.
// Assumes a 20-cycle nominal period and 3-flop input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module inrush_seq_monitor (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    reset,
   // Pins
   input wire inrush_seq_pkg::cmp_in_s cmp_in,
   input wire logic                    enable_n_in,
   input wire logic                    gate_on,
   input wire logic                    first_power_good_n_oe_n,
   input wire logic                    second_power_good_io_oe_n,
   input wire logic                    alert_n_oe_n,
   // Bus handshakes
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic [1:0]              s_axi_bresp,
   input wire logic                    s_axi_rvalid,
   input wire logic                    s_axi_arready
);
   import inrush_seq_pkg::*;
   logic start_ok;
   // Raw start conditions; sampled a little late to cover sync latency
   assign start_ok = cmp_in.supply_ok & cmp_in.uvh_above & cmp_in.uvl_above
                     & !cmp_in.ov_above & !enable_n_in;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_SHORT: assert property (
      cmp_in.short_circuit |-> ##[1:6] !gate_on) else $error("short");
   AST_EN_OFF: assert property (
      enable_n_in [*8] |-> !gate_on) else $error("enable off");
   AST_OV_OFF: assert property (
      cmp_in.ov_above [*8] |-> !gate_on) else $error("ov off");
   AST_UVL_OFF: assert property (
      !cmp_in.uvl_above [*8] |-> !gate_on && first_power_good_n_oe_n)
      else $error("uvl off");
   AST_GATE_ON: assert property (
      $rose(gate_on) |-> $past(start_ok, 2)) else $error("gate early");
   AST_PG1: assert property (
      $fell(first_power_good_n_oe_n) |-> $past(cmp_in.gate_high, 6)
      && $past(cmp_in.drain_low, 6)) else $error("pg1 early");
   AST_PG2: assert property (
      $fell(second_power_good_io_oe_n) |->
      !$past(first_power_good_n_oe_n, 30)) else $error("pg2 early");
   AST_RESET: assert property (disable iff (1'b0)
      reset |=> !gate_on && first_power_good_n_oe_n && alert_n_oe_n)
      else $error("reset state");
   AST_BHOLD: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("bresp dropped");
   AST_RHOLD: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
   COV_ON: cover property ($rose(gate_on));
   COV_PG2: cover property ($fell(second_power_good_io_oe_n));
   COV_ALERT: cover property ($fell(alert_n_oe_n));
endmodule
bind insertion_power_sequencer inrush_seq_monitor mon (.clk, .reset,
   .cmp_in, .enable_n_in, .gate_on, .first_power_good_n_oe_n,
   .second_power_good_io_oe_n, .alert_n_oe_n, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_rvalid, .s_axi_arready);
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the insertion power sequencer.
// Assumes a 20-cycle nominal period and an 8-cycle breaker timeout.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import inrush_seq_pkg::*;
   logic        clk = 0;
   logic        reset = 1;
   logic [8:0]  cmp = 9'h1C0;
   logic        en_n = 0, on_pin = 1, ext_n = 1, fail = 0;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
   logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [31:0] wdata = 32'h0;
   wire logic   gate_on, pg1, pg2, alert, gh, dl, wdog, pd, pgo;
   wire logic   awready, wready, bvalid, arready, rvalid;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   cmp_in_s     cin;
   int          error_cnt = 0, checks_done = 0, rnd;
   // Partner drives gate and drain sense, bench drives the rest
   assign cin = {cmp[8:4], dl, gh, cmp[1:0]};
   always #50 clk = ~clk;
   insertion_power_sequencer #(.NOMINAL_CYCLES(20), .BREAKER_CYCLES(8))
      insertion_power_sequencer_inst (.clk, .reset, .cmp_in(cin),
      .enable_n_in(en_n), .on_in(on_pin), .external_fault_in(ext_n),
      .power_good_watchdog_in(wdog), .gate_on, .gate_pulldown(pd),
      .first_power_good_n_oe_n(pg1), .alert_n_oe_n(alert),
      .second_power_good_io_in(pg2), .second_power_good_io_out(pgo),
      .second_power_good_io_oe_n(pg2), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   converter_model converter_model_inst (.clk, .fail, .gate_on,
      .pg2_n(pg2), .gate_high(gh), .drain_low(dl), .wdog_n(wdog));
   task automatic chk(input string n, input logic [7:0] e, s);
      checks_done++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Ready is raised late on purpose so the slave must hold its answer
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      awaddr <= a;
      wdata <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      do
      begin
         @(posedge clk);
         if (awready) awv <= 0;
         if (wready) wv <= 0;
      end
      while (!bvalid);
      bready <= 1;
      do @(posedge clk); while (!bvalid);
      bready <= 0;
      chk("bresp", er, bresp);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] m, e);
      araddr <= a;
      arv <= 1;
      do
      begin
         @(posedge clk);
         if (arready) arv <= 0;
      end
      while (!rvalid);
      rready <= 1;
      do @(posedge clk); while (!rvalid);
      rready <= 0;
      chk("rdata", e, rdata[7:0] & m);
      chk("rresp", 2'h0, rresp);
   endtask
   task automatic until_gate(input logic v);
      int n = 0;
      while (gate_on !== v && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      chk("gate_on", v, gate_on);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog: whole run is about 1000 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report;
   end
   initial
   begin
      rnd = $urandom(32'hE2AC02C3);
      repeat (8) @(posedge clk);
      reset <= 0;
      @(posedge clk);
      rd(4'h0, 8'hFF, 8'h03);
      rd(4'h4, 8'hFF, 8'h00);
      wr(4'hC, 8'h00, 2'h2);
      rnd = $urandom | 32'h80;
      wr(4'h4, rnd[7:0], 2'h0);
      rd(4'h4, 8'hFF, rnd[7:0]);
      until_gate(1'b1);
      rd(4'h0, 8'h08, 8'h08);
      repeat (200) @(posedge clk);
      chk("pg1", 1'b0, pg1);
      chk("pg2", 1'b0, pg2);
      chk("second_power_good_io_out", 1'b0, pgo);
      chk("gate_on", 1'b1, gate_on);
      ext_n <= 0;
      repeat (10) @(posedge clk);
      ext_n <= 1;
      repeat (6) @(posedge clk);
      chk("gate_on", 1'b1, gate_on);
      chk("alert", 1'b0, alert);
      rd(4'h8, 8'h80, 8'h80);
      wr(4'h8, 8'hFF, 2'h0);
      repeat (2) @(posedge clk);
      chk("alert", 1'b1, alert);
      cmp[4] <= 1;
      repeat (10) @(posedge clk);
      chk("gate_on", 1'b0, gate_on);
      chk("pg1", 1'b0, pg1);
      cmp[4] <= 0;
      repeat (8) @(posedge clk);
      chk("gate_on", 1'b1, gate_on);
      cmp[1] <= 1;
      repeat (5) @(posedge clk);
      cmp[1] <= 0;
      repeat (8) @(posedge clk);
      chk("gate_on", 1'b1, gate_on);
      cmp[1] <= 1;
      repeat (20) @(posedge clk);
      cmp[1] <= 0;
      chk("gate_on", 1'b0, gate_on);
      chk("pg1", 1'b1, pg1);
      rd(4'h8, 8'h04, 8'h04);
      repeat (100) @(posedge clk);
      chk("gate_on", 1'b0, gate_on);
      on_pin <= 0;
      repeat (8) @(posedge clk);
      rd(4'h8, 8'h1F, 8'h00);
      on_pin <= 1;
      until_gate(1'b1);
      cmp[0] <= 1;
      repeat (8) @(posedge clk);
      cmp[0] <= 0;
      chk("gate_on", 1'b0, gate_on);
      chk("pulldown", 1'b1, pd);
      rd(4'h8, 8'h10, 8'h10);
      en_n <= 1;
      repeat (8) @(posedge clk);
      chk("gate_on", 1'b0, gate_on);
      rd(4'h8, 8'h20, 8'h20);
      en_n <= 0;
      repeat (8) @(posedge clk);
      rd(4'h8, 8'h3F, 8'h20);
      until_gate(1'b1);
      repeat (100) @(posedge clk);
      cmp[6] <= 0;
      repeat (10) @(posedge clk);
      chk("gate_on", 1'b0, gate_on);
      chk("pg1", 1'b1, pg1);
      cmp[5] <= 1;
      repeat (8) @(posedge clk);
      rd(4'h8, 8'h1F, 8'h00);
      cmp[5] <= 0;
      cmp[6] <= 1;
      fail <= 1;
      until_gate(1'b1);
      repeat (300) @(posedge clk);
      chk("gate_on", 1'b0, gate_on);
      rd(4'h8, 8'h08, 8'h08);
      final_report;
   end
endmodule
`default_nettype wire
